// ---- logic/adcs_top.sv ----
/*
  Sequencer for two successive-approximation converters: triggers,
  regular and preempted groups, oversampling, monitor, dma, irq.
  Assumes analog cores outside that sample while the sample strobe is
  high and present a 12-bit result before the slot ends.
*/
// Design decisions made here: the placing of the registers and the APB interface to the registers.
// Notes on behaviour
// - resolution 12/10/8/6 bits plus calibration
// - fewer conversion cycles at lower resolution
// - sixteen external channels shared by both
// - per-channel sample time applied per slot
// - oversampling 2 to 256, up to 16 bits
// - software trigger and own selection per group
// - hardware trigger with programmable edge
// - sequential mode converts whole group
// - repeated mode restarts until stopped
// - synchronous or shifted dual operation
// - monitor one, some or all channels
// - out-of-window result raises interrupt
// - each converter requests dma per regular-group result
// - channel 16 is temperature sensor
// - channel 17 is internal reference
// - channel 18 reads quarter battery voltage
`default_nettype none
module adcs_top #(
  parameter int TRIG_N = 8
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // hardware triggers
  input wire logic [TRIG_N-1:0] trig_in,
  // converter 1
  input wire logic [11:0] ana1_res,
  output logic [4:0] ana1_chan,
  output logic ana1_sample,
  // converter 2
  input wire logic [11:0] ana2_res,
  output logic [4:0] ana2_chan,
  output logic ana2_sample,
  // shared analog control
  output logic ana_cal,
  output logic temp_sense_en,
  output logic ref_voltage_en,
  output logic battery_div_en,
  // dma
  output logic dma1_req,
  input wire logic dma1_ack,
  output logic dma2_req,
  input wire logic dma2_ack,
  // interrupt
  output logic irq
);
  import adcs_pkg::*;

  typedef struct packed {
    adcs_st_t state;
    logic [31:0] ctrl, trig, ovs, smp0, smp1, rseq, pseq, r2seq;
    logic [31:0] mon, thr;
    logic [SW-1:0] sts, msk;
    logic [9:0] t;
    logic grp, ract, ppend;
    logic [2:0] idx;
    logic [1:0] pidx;
    logic [7:0] osc;
    logic [6:0] calc;
    logic [19:0] acc1, acc2;
    logic [15:0] rd1, rd2;
    logic rv1, rv2;
    logic [3:0][15:0] pd;
    logic [TRIG_N-1:0] ts1, ts2, tprev;
    logic [11:0] r1s1, r1s2, r2s1, r2s2;
    logic [31:0] prdata;
    logic pready, pslverr, irq, dq1, dq2;
    logic [4:0] c1, c2;
    logic so1, so2, calo, tse, rve, bde;
  } adcs_state_t;

  adcs_state_t s, n;
  logic slot_end, fin, grp_end, swr, swp, rtr, ptr, wr, rd, hit;
  logic [SW-1:0] ev;
  logic [31:0] rdv;
  logic [4:0] ch1, ch2;
  logic [9:0] sm1, sm2, cv, d, e1, e2;
  logic [15:0] v1, v2, r1, r2;
  logic [19:0] a1, a2;
  logic [1:0] res, dm;
  logic [7:0] olast;

  // edge qualifier: 0 off, 1 rising, 2 falling, 3 both
  function automatic logic edg(input logic c, input logic p,
                               input logic [1:0] m);
    case (m)
      2'h1: edg = c & ~p;
      2'h2: edg = ~c & p;
      2'h3: edg = c ^ p;
      default: edg = 1'b0;
    endcase
  endfunction

  // sample time of a channel: 2 << code cycles
  function automatic logic [9:0] smpc(input logic [4:0] ch,
                                      input logic [31:0] a,
                                      input logic [31:0] b);
    logic [2:0] c;
    c = (ch < 5'd10) ? a[ch*3 +: 3] : b[(ch-5'd10)*3 +: 3];
    smpc = 10'h002 << c;
  endfunction

  // monitor hit: channel selected and outside window
  function automatic logic mhit(input logic [31:0] m,
                                input logic [31:0] th,
                                input logic [4:0] ch,
                                input logic [15:0] v);
    mhit = m[M_EN] && (ch < 5'd19) && m[ch] &&
           (v > th[31:16] || v < th[15:0]);
  endfunction

  always_comb begin
    n = s;
    ev = '0;
    slot_end = 1'b0;
    fin = 1'b0;
    grp_end = 1'b0;
    r1 = '0;
    r2 = '0;
    // two-stage synchronisers for pins and analog results
    n.ts1 = trig_in;
    n.ts2 = s.ts1;
    n.tprev = s.ts2;
    n.r1s1 = ana1_res;
    n.r1s2 = s.r1s1;
    n.r2s1 = ana2_res;
    n.r2s2 = s.r2s1;
    rtr = edg(s.ts2[s.trig[T_RSEL +: 3]], s.tprev[s.trig[T_RSEL +: 3]],
              s.trig[T_REDG +: 2]);
    ptr = edg(s.ts2[s.trig[T_PSEL +: 3]], s.tprev[s.trig[T_PSEL +: 3]],
              s.trig[T_PEDG +: 2]);
    // apb: setup cycle registers answer, access sees pready
    wr = psel && penable && s.pready && pwrite && !s.pslverr;
    rd = psel && penable && s.pready && !pwrite && !s.pslverr;
    n.pready = psel && !penable;
    hit = 1'b1;
    rdv = '0;
    case (paddr)
      A_CTRL: rdv = s.ctrl;
      A_TRIG: rdv = s.trig;
      A_OVS: rdv = s.ovs;
      A_SMP0: rdv = s.smp0;
      A_SMP1: rdv = s.smp1;
      A_RSEQ: rdv = s.rseq;
      A_PSEQ: rdv = s.pseq;
      A_R2SEQ: rdv = s.r2seq;
      A_MON: rdv = s.mon;
      A_THR: rdv = s.thr;
      A_STS: rdv = {26'h0, s.sts};
      A_MSK: rdv = {26'h0, s.msk};
      A_RDAT: rdv = {s.rd2, s.rd1};
      A_PD01: rdv = {s.pd[1], s.pd[0]};
      A_PD23: rdv = {s.pd[3], s.pd[2]};
      A_STAT: rdv = {22'h0, s.rv2, s.rv1, s.idx, s.state,
                     s.ppend, s.ract, s.grp};
      default: hit = 1'b0;
    endcase
    if (psel && !penable) begin
      n.prdata = rdv;
      n.pslverr = !hit;
    end
    // software triggers are one-shot control bits
    swr = wr && paddr == A_CTRL && pwdata[C_SWR];
    swp = wr && paddr == A_CTRL && pwdata[C_SWP];
    if (wr) begin
      case (paddr)
        A_CTRL: n.ctrl = pwdata & ~(32'h1 << C_SWR) & ~(32'h1 << C_SWP);
        A_TRIG: n.trig = pwdata;
        A_OVS: n.ovs = pwdata;
        A_SMP0: n.smp0 = pwdata;
        A_SMP1: n.smp1 = pwdata;
        A_RSEQ: n.rseq = pwdata;
        A_PSEQ: n.pseq = pwdata;
        A_R2SEQ: n.r2seq = pwdata;
        A_MON: n.mon = pwdata;
        A_THR: n.thr = pwdata;
        A_STS: n.sts = s.sts & ~pwdata[SW-1:0];
        A_MSK: n.msk = pwdata[SW-1:0];
        default: ;
      endcase
    end
    // reading results or a dma grant frees the data slot
    if (rd && paddr == A_RDAT) begin
      n.rv1 = 1'b0;
      n.rv2 = 1'b0;
    end
    if (dma1_ack) n.rv1 = 1'b0;
    if (dma2_ack) n.rv2 = 1'b0;
    // each group keeps its own pending start
    if ((rtr || swr) && s.ctrl[C_EN] && !s.ract) begin
      n.ract = 1'b1;
      n.idx = '0;
    end
    if ((ptr || swp) && s.ctrl[C_EN]) n.ppend = 1'b1;
    // slot channels from the shared pool
    res = s.ctrl[C_RES +: 2];
    dm = s.ctrl[C_DUAL +: 2];
    ch1 = s.grp ? s.pseq[s.pidx*5 +: 5] :
          (s.ctrl[C_SEQ] ? s.rseq[s.idx*5 +: 5] : s.rseq[4:0]);
    ch2 = s.grp ? s.pseq[s.pidx*5 +: 5] :
          (s.ctrl[C_SEQ] ? s.r2seq[s.idx*5 +: 5] : s.r2seq[4:0]);
    // sample time looked up per converted channel
    sm1 = smpc(ch1, s.smp0, s.smp1);
    sm2 = smpc(ch2, s.smp0, s.smp1);
    // two cycles fewer per resolution step
    cv = 10'(RES_MAX) - {7'h0, res, 1'b0} + 10'(SYNC_LAT);
    // second converter starts d cycles late in shift mode
    d = (dm == DM_SHIFT) ? {6'h0, s.ctrl[C_SHD +: 4]} : 10'h000;
    e1 = sm1 + cv - 10'h001;
    e2 = (dm == DM_IND) ? 10'h000 : d + sm2 + cv - 10'h001;
    v1 = {4'h0, s.r1s2 >> {res, 1'b0}};
    v2 = {4'h0, s.r2s2 >> {res, 1'b0}};
    a1 = s.acc1 + {4'h0, v1};
    a2 = s.acc2 + {4'h0, v2};
    // 2 << ratio samples; 8-bit wrap gives 255 at 256
    olast = (8'h02 << s.ovs[O_RAT +: 3]) - 8'h01;
    unique case (s.state)
      ST_IDLE: begin
        if (s.ctrl[C_CAL]) begin
          n.state = ST_CAL;
          n.calc = '0;
        end else if (s.ctrl[C_EN] && n.ppend) begin
          n.state = ST_CONV;
          n.grp = 1'b1;
          n.pidx = '0;
          n.ppend = 1'b0;
          n.t = '0;
        end else if (s.ctrl[C_EN] && n.ract) begin
          n.state = ST_CONV;
          n.grp = 1'b0;
          n.t = '0;
        end
      end
      // calibration runs a fixed window, then clears its bit
      ST_CAL: begin
        n.calc = s.calc + 7'h01;
        if (s.calc == 7'(CAL_CYC - 1)) begin
          n.state = ST_IDLE;
          n.ctrl[C_CAL] = 1'b0;
          ev[S_CAL] = 1'b1;
        end
      end
      ST_CONV: begin
        n.t = s.t + 10'h001;
        if (!s.ctrl[C_EN]) begin
          // disabling stops repeat mode at once; a cleared repeat bit stops it at group end
          n.state = ST_IDLE;
          n.ract = 1'b0;
          n.ppend = 1'b0;
          n.osc = '0;
          n.acc1 = '0;
          n.acc2 = '0;
        end else if (s.t == ((e1 > e2) ? e1 : e2)) begin
          slot_end = 1'b1;
          n.t = '0;
          fin = !s.ovs[O_EN] || s.osc == olast;
          if (!fin) begin
            n.osc = s.osc + 8'h01;
            n.acc1 = a1;
            n.acc2 = a2;
          end else begin
            n.osc = '0;
            n.acc1 = '0;
            n.acc2 = '0;
            r1 = s.ovs[O_EN] ? 16'(a1 >> s.ovs[O_SH +: 4]) : v1;
            r2 = s.ovs[O_EN] ? 16'(a2 >> s.ovs[O_SH +: 4]) : v2;
            ev[S_EOC] = 1'b1;
            // channel mask selects one, some or all
            ev[S_VMON] = mhit(s.mon, s.thr, ch1, r1) ||
                         (dm != DM_IND && mhit(s.mon, s.thr, ch2, r2));
            if (!s.grp) begin
              // new result raises the data-valid request
              ev[S_OVR] = s.rv1;
              n.rd1 = r1;
              n.rv1 = 1'b1;
              if (dm != DM_IND) begin
                n.rd2 = r2;
                n.rv2 = 1'b1;
              end
              // walk the list in sequential mode
              if (!s.ctrl[C_SEQ] || s.idx == s.trig[T_RLEN +: 3]) begin
                grp_end = 1'b1;
                ev[S_EOS] = 1'b1;
                n.idx = '0;
                n.ract = s.ctrl[C_REP];
              end else begin
                n.idx = s.idx + 3'h1;
              end
              // preempted group cuts in once a regular result is complete
              if (n.ppend || !n.ract) n.state = ST_IDLE;
            end else begin
              n.pd[s.pidx] = r1;
              if (s.pidx == s.pseq[P_LEN +: 2]) begin
                ev[S_PEOS] = 1'b1;
                n.state = ST_IDLE;
              end else begin
                n.pidx = s.pidx + 2'h1;
              end
            end
          end
        end
      end
      default: n.state = ST_IDLE;
    endcase
    // set wins over a clear in the same cycle
    n.sts = n.sts | ev;
    // level interrupt from unmasked sticky bits
    n.irq = |(n.sts & n.msk);
    // dma request while a result waits
    n.dq1 = n.rv1 && n.ctrl[C_DMA];
    n.dq2 = n.rv2 && n.ctrl[C_DMA];
    // analog strobes lag the slot counter by one cycle
    n.c1 = ch1;
    n.c2 = ch2;
    n.so1 = s.state == ST_CONV && !slot_end && s.t < sm1;
    n.so2 = s.state == ST_CONV && !slot_end && dm != DM_IND &&
            s.t >= d && s.t < d + sm2;
    n.calo = n.state == ST_CAL;
    // temperature sensor routed on channel 16
    n.tse = s.state == ST_CONV && ch1 == TEMP_SENSE_CHANNEL;
    n.rve = s.state == ST_CONV && ch1 == REF_VOLTAGE_CHANNEL;
    // quarter divider switched in on channel 18
    n.bde = s.state == ST_CONV && ch1 == BATTERY_MONITOR_CHANNEL;
  end

  // single state register, frozen while ce is low
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else if (ce) begin
      s <= n;
    end
  end

  // outputs come straight from the state register
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign irq = s.irq;
  assign dma1_req = s.dq1;
  assign dma2_req = s.dq2;
  assign ana1_chan = s.c1;
  assign ana2_chan = s.c2;
  assign ana1_sample = s.so1;
  assign ana2_sample = s.so2;
  assign ana_cal = s.calo;
  assign temp_sense_en = s.tse;
  assign ref_voltage_en = s.rve;
  assign battery_div_en = s.bde;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn || !ce);

  res_six_a: assert property (
    fin && !s.grp && !s.ovs[O_EN] && res == 2'h3 |=> s.rd1[15:6] == 0)
    else $error("6-bit result has high bits set");
  cal_run_a: assert property (
    s.state == ST_IDLE && s.ctrl[C_CAL] |=> ana_cal [*8])
    else $error("calibration strobe too short");
  samp_min_a: assert property (
    $rose(ana1_sample) |-> ana1_sample [*2])
    else $error("sample window under two cycles");
  sw_start_a: assert property (
    swr && s.ctrl[C_EN] && !s.ract |=> s.ract)
    else $error("software trigger not taken");
  seq_step_a: assert property (
    fin && !s.grp && !grp_end |=> s.idx == $past(s.idx) + 3'h1)
    else $error("sequence index did not advance");
  rep_keep_a: assert property (
    grp_end && s.ctrl[C_REP] && s.ctrl[C_EN] |=> s.ract && s.idx == 0)
    else $error("repeat mode dropped the group");
  shift_gap_a: assert property (
    dm == DM_SHIFT && d != 0 && $rose(ana1_sample) |-> !ana2_sample)
    else $error("shifted converter sampled early");
  mon_irq_a: assert property (
    ev[S_VMON] && s.msk[S_VMON] |=> irq)
    else $error("monitor event without interrupt");
  dma_req_a: assert property (
    fin && !s.grp && s.ctrl[C_DMA] && !dma1_ack |=> ##1 dma1_req)
    else $error("result without dma request");
  temp_ch_a: assert property (
    s.state == ST_CONV && ch1 == TEMP_SENSE_CHANNEL |=> temp_sense_en)
    else $error("temperature path not enabled");
  eoc_set_a: assert property (
    fin |=> s.sts[S_EOC])
    else $error("end of conversion flag missing");
endmodule
`default_nettype wire

// ---- logic/adcs_pkg.sv ----
/*
  Constants for the dual converter sequencer: register map, field
  positions, status bits, timing counts and the sequencer state type.
  Assumes a 20 MHz core clock; the calibration count below derives from it.
*/
`default_nettype none
package adcs_pkg;
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_TRIG = 8'h04;
  localparam logic [7:0] A_OVS = 8'h08;
  localparam logic [7:0] A_SMP0 = 8'h0C;
  localparam logic [7:0] A_SMP1 = 8'h10;
  localparam logic [7:0] A_RSEQ = 8'h14;
  localparam logic [7:0] A_PSEQ = 8'h18;
  localparam logic [7:0] A_R2SEQ = 8'h1C;
  localparam logic [7:0] A_MON = 8'h20;
  localparam logic [7:0] A_THR = 8'h24;
  localparam logic [7:0] A_STS = 8'h28;
  localparam logic [7:0] A_MSK = 8'h2C;
  localparam logic [7:0] A_RDAT = 8'h30;
  localparam logic [7:0] A_PD01 = 8'h34;
  localparam logic [7:0] A_PD23 = 8'h38;
  localparam logic [7:0] A_STAT = 8'h3C;
  // control fields
  localparam int C_EN = 0;
  localparam int C_CAL = 1;
  localparam int C_RES = 2;
  localparam int C_SEQ = 4;
  localparam int C_REP = 5;
  localparam int C_DUAL = 6;
  localparam int C_DMA = 8;
  localparam int C_SWR = 9;
  localparam int C_SWP = 10;
  localparam int C_SHD = 12;
  // trigger, oversampling, sequence and monitor fields
  localparam int T_RSEL = 0;
  localparam int T_REDG = 3;
  localparam int T_PSEL = 8;
  localparam int T_PEDG = 11;
  localparam int T_RLEN = 16;
  localparam int O_EN = 0;
  localparam int O_RAT = 1;
  localparam int O_SH = 4;
  localparam int P_LEN = 20;
  localparam int M_EN = 19;
  // status bits
  localparam int S_EOC = 0;
  localparam int S_EOS = 1;
  localparam int S_PEOS = 2;
  localparam int S_VMON = 3;
  localparam int S_OVR = 4;
  localparam int S_CAL = 5;
  localparam int SW = 6;
  // dual modes
  localparam logic [1:0] DM_IND = 2'h0;
  localparam logic [1:0] DM_SYNC = 2'h1;
  localparam logic [1:0] DM_SHIFT = 2'h2;
  // internal channels of converter 1
  localparam logic [4:0] TEMP_SENSE_CHANNEL = 5'h10;
  localparam logic [4:0] REF_VOLTAGE_CHANNEL = 5'h11;
  localparam logic [4:0] BATTERY_MONITOR_CHANNEL = 5'h12;
  // timing
  localparam int CLK_NS = 50;
  localparam int CAL_NS = 3200;
  localparam int CAL_CYC = (CAL_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_LAT = 2;
  localparam int RES_MAX = 12;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_CONV = 2'h1,
    ST_CAL = 2'h2
  } adcs_st_t;
endpackage
`default_nettype wire

// ---- tb/adcs_ana_model.sv ----
/*
  Behavioural analog core for one converter: settles a result code per
  channel while the sequencer samples, then holds it.
  Assumes the sequencer keeps the channel select steady while sampling.
*/
`default_nettype none
module adcs_ana_model #(
  parameter logic [11:0] BASE = 12'h100
) (
  // sequencer side
  input wire logic core_clk,
  input wire logic [4:0] chan,
  input wire logic sample,
  // converted code
  output logic [11:0] res
);
  timeunit 1ns;
  timeprecision 1ns;
  // base plus channel so every input is recognisable in the result
  initial res = 12'h000;
  // a real core holds its last code between samples, so no reset here
  always @(posedge core_clk) begin
    if (sample) begin
      res <= BASE + {7'h00, chan};
    end
  end
endmodule
`default_nettype wire

// ---- tb/adc_conversion_sequencer_tb_top.sv ----
/*
  Self-checking bench for the converter sequencer: apb register tasks,
  conversion runs timed by the interrupt, port monitors.
  Assumes the two analog cores are the behavioural models beside it.
*/
`default_nettype none
module adc_conversion_sequencer_tb_top;
  import adcs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'h0, rstn = 1'h0, ce = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, rerr;
  logic [7:0] paddr = 8'h00, trig_in = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic pready, pslverr, ana1_sample, ana2_sample, ana_cal, irq;
  logic [11:0] ana1_res, ana2_res;
  logic [4:0] ana1_chan, ana2_chan;
  logic temp_sense_en, ref_voltage_en, battery_div_en, dma1_req, dma2_req;
  logic dma1_ack = 1'h0, dma2_ack = 1'h0, sync_on = 1'h0;
  int failures = 0, tests_run = 0, nsmp = 0, swid = 0, cwid = 0;
  int sc = 0, cc = 0, m, k;
  int n [4];

  // device and its two analog cores
  adcs_top u_dut (.core_clk(core_clk), .rstn(rstn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .trig_in(trig_in),
    .ana1_res(ana1_res), .ana1_chan(ana1_chan), .ana1_sample(ana1_sample),
    .ana2_res(ana2_res), .ana2_chan(ana2_chan), .ana2_sample(ana2_sample),
    .ana_cal(ana_cal), .temp_sense_en(temp_sense_en),
    .ref_voltage_en(ref_voltage_en), .battery_div_en(battery_div_en),
    .dma1_req(dma1_req), .dma1_ack(dma1_ack), .dma2_req(dma2_req),
    .dma2_ack(dma2_ack), .irq(irq));
  adcs_ana_model #(.BASE(12'h100)) u_ana1 (.core_clk(core_clk),
    .chan(ana1_chan), .sample(ana1_sample), .res(ana1_res));
  adcs_ana_model #(.BASE(12'h200)) u_ana2 (.core_clk(core_clk),
    .chan(ana2_chan), .sample(ana2_sample), .res(ana2_res));

  // 20 MHz core clock
  initial begin
    forever #25 core_clk = ~core_clk;
  end

  task automatic print_verdict();
    if (failures == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic tmo();
    failures++;
    $display("ERROR %0t: wait timed out", $time);
    print_verdict();
  endtask

  // one apb transfer; an idle cycle after it keeps psel single-driven
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int t;
    t = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    do begin
      @(posedge core_clk);
      t++;
    end while (pready !== 1'h1 && t < 50);
    if (t >= 50) tmo();
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] msk,
                     input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk(rdata & msk, e);
  endtask

  // cycles until irq; the same fixed offset in every run cancels out
  task automatic wirq(output int t);
    t = 0;
    while (irq !== 1'h1) begin
      @(posedge core_clk);
      t++;
      if (t > 3000) tmo();
    end
    repeat (2) @(posedge core_clk);
  endtask

  task automatic run(input logic [31:0] c, input logic [31:0] msk,
                     output int t);
    wr(A_STS, 32'h3F);
    wr(A_MSK, msk);
    wr(A_CTRL, c);
    wirq(t);
  endtask

  // pulse widths, sample count and source enables while sampling
  always @(posedge core_clk) begin
    if (ana1_sample === 1'h1) begin
      sc++;
      chk(temp_sense_en, ana1_chan == TEMP_SENSE_CHANNEL);
      chk(ref_voltage_en, ana1_chan == REF_VOLTAGE_CHANNEL);
      chk(battery_div_en, ana1_chan == BATTERY_MONITOR_CHANNEL);
    end else if (sc != 0) begin
      swid = sc;
      sc = 0;
      nsmp++;
    end
    if (sync_on) chk(ana2_sample, ana1_sample);
    if (ana_cal === 1'h1) cc++;
    else if (cc != 0) begin
      cwid = cc;
      cc = 0;
    end
  end

  initial begin
    repeat (6) @(posedge core_clk);
    rstn <= 1'h1;
    @(posedge core_clk);
    for (int a = 0; a < 64; a += 4) begin
      bus(1'h0, 8'(a), 32'h0);
      chk(rdata, 32'h0);
      chk(rerr, 1'h0);
    end
    // unmapped address errors, result word ignores writes
    bus(1'h0, 8'h40, 32'h0);
    chk(rerr, 1'h1);
    wr(A_RDAT, 32'hFFFF_FFFF);
    rdc(A_RDAT, 32'hFFFF_FFFF, 32'h0);
    run(32'h3, 32'h20, m);
    chk(cwid, CAL_CYC);
    // single conversion of the temperature channel
    wr(A_RSEQ, 32'h10);
    run(32'h201, 32'h1, m);
    chk(swid, 2);
    rdc(A_STS, 32'h1, 32'h1);
    rdc(A_RDAT, 32'hFFFF, 32'h110);
    wr(A_STS, 32'h1);
    rdc(A_STS, 32'h1, 32'h0);
    chk(irq, 1'h0);
    // two cycles fewer per resolution step
    for (int r = 0; r < 4; r++) begin
      run(32'h201 | (r << C_RES), 32'h1, n[r]);
      chk(n[0] - n[r], 2 * r);
    end
    // channel sixteen gets its own sample code
    wr(A_SMP1, 32'h0004_0000);
    run(32'h201, 32'h1, m);
    chk(swid, 4);
    wr(A_SMP1, 32'h0);
    sync_on = 1'h1;
    run(32'h241, 32'h1, k);
    sync_on = 1'h0;
    // shifted pair: second core three cycles late lengthens slot
    run(32'h3281, 32'h1, m);
    chk(m - k, 3);
    // two samples summed, shifted by one, keep the code
    wr(A_OVS, 32'h11);
    k = nsmp;
    run(32'h201, 32'h1, m);
    chk(nsmp - k, 2);
    rdc(A_RDAT, 32'hFFFF, 32'h110);
    wr(A_OVS, 32'h0);
    // preempted group started by its own software trigger
    wr(A_PSEQ, 32'h11);
    run(32'h401, 32'h4, m);
    rdc(A_PD01, 32'hFFFF, 32'h111);
    // one trigger converts channels 16, 17, 18
    wr(A_RSEQ, 32'h4A30);
    wr(A_TRIG, 32'h0002_0000);
    k = nsmp;
    run(32'h211, 32'h2, m);
    chk(nsmp - k, 3);
    rdc(A_RDAT, 32'hFFF, 32'h112);
    // monitor window on selected channel only
    wr(A_RSEQ, 32'h10);
    wr(A_TRIG, 32'h0);
    wr(A_THR, 32'h0050_0000);
    wr(A_MON, 32'h000A_0000);
    run(32'h201, 32'h1, m);
    rdc(A_STS, 32'h8, 32'h0);
    wr(A_MON, 32'h0009_0000);
    run(32'h201, 32'h8, m);
    rdc(A_STS, 32'h8, 32'h8);
    wr(A_MON, 32'h0);
    // rising edge on line zero starts the group
    wr(A_TRIG, 32'h8);
    wr(A_CTRL, 32'h1);
    wr(A_STS, 32'h3F);
    wr(A_MSK, 32'h1);
    repeat (20) @(posedge core_clk);
    chk(irq, 1'h0);
    trig_in <= 8'h01;
    wirq(m);
    trig_in <= 8'h00;
    rdc(A_STS, 32'h1, 32'h1);
    wr(A_TRIG, 32'h0);
    wr(A_CTRL, 32'h301);
    k = 0;
    while (dma1_req !== 1'h1) begin
      @(posedge core_clk);
      k++;
      if (k > 3000) tmo();
    end
    dma1_ack <= 1'h1;
    dma2_ack <= 1'h1;
    @(posedge core_clk);
    dma1_ack <= 1'h0;
    dma2_ack <= 1'h0;
    repeat (2) @(posedge core_clk);
    chk(dma1_req, 1'h0);
    // repeats without triggers, stops when disabled
    k = nsmp;
    wr(A_CTRL, 32'h221);
    m = 0;
    while (nsmp < k + 3) begin
      @(posedge core_clk);
      m++;
      if (m > 3000) tmo();
    end
    wr(A_CTRL, 32'h0);
    repeat (60) @(posedge core_clk);
    k = nsmp;
    repeat (100) @(posedge core_clk);
    chk(nsmp, k);
    print_verdict();
  end
endmodule
`default_nettype wire
